// >>> common/gpp_pkg.sv
// Purpose: types shared by the five-pin port
// Assumes: nothing
// Notes: pin groups travel as packed structs
package gpp_pkg;
    typedef logic [4:0] gpp_pins_t;
    typedef struct packed {
        logic d;
        logic e;
        logic j;
    } gpp_pullup_s;
    // per-pin peripheral override request
    typedef struct packed {
        gpp_pins_t out_en;
        gpp_pins_t out_val;
        gpp_pins_t in_force;
    } gpp_ovr_s;
endpackage : gpp_pkg

// >>> common/gpp_regs.svh
// Purpose: register offsets, field positions and reset values of the five-pin port
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are local to this block
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH
`define GPP_OFF_PORT 2'h0
`define GPP_OFF_LAT 2'h1
`define GPP_OFF_DIR 2'h2
`define GPP_PIN_MSB 4
`define GPP_PU_D_BIT 7
`define GPP_PU_E_BIT 6
`define GPP_PU_J_BIT 5
`define GPP_LAT_RST 5'h00
`define GPP_DIR_RST 5'h1f
`define GPP_PU_RST 3'h0
`endif

// >>> dv/gpp_pad_model.sv
// Purpose: pad model closing the loop from port drivers back to pin levels
// Assumes: no pull-ups on these pads
// Notes: undriven pads show the level that the far side puts on them
`timescale 1ns/100ps
module gpp_pad_model (
    input wire gpp_pkg::gpp_pins_t pin_out,
    input wire gpp_pkg::gpp_pins_t pin_oe,
    input wire gpp_pkg::gpp_pins_t ext_lvl,
    output gpp_pkg::gpp_pins_t pin_in
);
    // a receive pin is only an undriven pad fed from outside
    assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule : gpp_pad_model

// >>> dv/test_gpp_port.sv
// Purpose: register and pin override checks of the five-pin port
// Assumes: read data valid one cycle after the read strobe
// Notes: far side pads held at 5'h0a while undriven
`timescale 1ns/100ps
`include "gpp_regs.svh"
module test_gpp_port;
    logic clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    gpp_pkg::gpp_pins_t pin_in, pin_out, pin_oe, ext_lvl = 5'h0a;
    gpp_pkg::gpp_pullup_s membus_pullup_en;
    logic [2:0] capcomp_en = 3'h0, capcomp_out = 3'h0, enh_pwm_en = 3'h0, enh_pwm_out = 3'h0;
    logic [2:0] enh_pwm_shutdown = 3'h0, enh_pwm_shutdown_tristate = 3'h0, pmp_addr = 3'h0;
    logic pmp_addr_en = 1'h0, pmp_chip_select_one_en = 1'h0, pmp_chip_select_one = 1'h0;
    logic pmp_chip_select_one_in_mode = 1'h0, pmp_chip_select_two_en = 1'h0, pmp_chip_select_two = 1'h0;
    logic serial_two_transmit_en = 1'h0, serial_two_transmit = 1'h0, serial_two_sync_data_oe = 1'h0;
    logic serial_two_sync_data = 1'h0, pmp_chip_select_one_in;
    int err_count = 0;
    int n_tests = 0;
    gpp_port gpp_port_inst (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in,
        .pin_out, .pin_oe, .membus_pullup_en, .capcomp_en, .capcomp_out, .enh_pwm_en, .enh_pwm_out,
        .enh_pwm_shutdown, .enh_pwm_shutdown_tristate, .pmp_addr_en, .pmp_addr, .pmp_chip_select_one_en,
        .pmp_chip_select_one, .pmp_chip_select_one_in_mode, .pmp_chip_select_two_en, .pmp_chip_select_two,
        .pmp_chip_select_one_in, .serial_two_transmit_en, .serial_two_transmit, .serial_two_sync_data_oe,
        .serial_two_sync_data);
    gpp_pad_model gpp_pad_model_inst (.pin_out, .pin_oe, .ext_lvl, .pin_in);
    always #5 clk = ~clk;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr
    // read data stand in the cycle after the strobe; sampled mid-cycle
    task rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(negedge clk);
        check(reg_rdata, exp);
    endtask : rd
    // oe and driven levels checked together; undriven outputs are don't care
    task pins(input gpp_pkg::gpp_pins_t oe, input gpp_pkg::gpp_pins_t val);
        @(negedge clk);
        check({3'h0, pin_oe}, {3'h0, oe});
        check({3'h0, pin_out & oe}, {3'h0, val});
    endtask : pins
    task test_done;
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    initial begin
        #100000;
        err_count++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'h1;
        @(posedge clk);
        rd(`GPP_OFF_DIR, 8'h1f);
        rd(`GPP_OFF_PORT, 8'h0a);
        pins(5'h00, 5'h00);
        wr(`GPP_OFF_PORT, 8'he5);
        @(negedge clk);
        check({5'h0, membus_pullup_en}, 8'h07);
        rd(`GPP_OFF_LAT, 8'h05);
        rd(`GPP_OFF_PORT, 8'hea);
        wr(`GPP_OFF_DIR, 8'hff);
        rd(`GPP_OFF_DIR, 8'h1f);
        wr(`GPP_OFF_LAT, 8'hfa);
        rd(`GPP_OFF_LAT, 8'h1a);
        wr(`GPP_OFF_DIR, 8'h04);
        pins(5'h1b, 5'h1a);
        rd(`GPP_OFF_PORT, 8'hfa);
        wr(`GPP_OFF_DIR, 8'h1f);
        @(posedge clk);
        pmp_addr_en <= 1'h1;
        pmp_addr <= 3'h7;
        pmp_chip_select_two_en <= 1'h1;
        pmp_chip_select_two <= 1'h1;
        pins(5'h17, 5'h17);
        rd(`GPP_OFF_DIR, 8'h1f);
        @(posedge clk);
        pmp_chip_select_one_en <= 1'h1;
        enh_pwm_en <= 3'h3;
        enh_pwm_out <= 3'h2;
        pins(5'h1f, 5'h1e);
        @(posedge clk);
        enh_pwm_shutdown <= 3'h2;
        enh_pwm_shutdown_tristate <= 3'h2;
        @(negedge clk);
        check({3'h0, pin_oe}, 8'h17);
        @(posedge clk);
        enh_pwm_en <= 3'h0;
        pmp_chip_select_one_in_mode <= 1'h1;
        @(negedge clk);
        check({7'h0, pmp_chip_select_one_in}, 8'h01);
        check({3'h0, pin_oe}, 8'h17);
        @(posedge clk);
        pmp_addr_en <= 1'h0;
        pmp_chip_select_one_en <= 1'h0;
        pmp_chip_select_two_en <= 1'h0;
        wr(`GPP_OFF_LAT, 8'h00);
        wr(`GPP_OFF_DIR, 8'h00);
        @(posedge clk);
        capcomp_en <= 3'h7;
        capcomp_out <= 3'h7;
        serial_two_transmit_en <= 1'h1;
        serial_two_transmit <= 1'h1;
        serial_two_sync_data_oe <= 1'h1;
        serial_two_sync_data <= 1'h1;
        pins(5'h1f, 5'h1f);
        rd(2'h3, 8'h00);
        test_done;
    end
endmodule : test_gpp_port

// >>> rtl/gpp_port.sv
// Purpose: five-pin bidirectional port with peripheral overrides and memory bus pull-up control
// Assumes: one clock, register strobes one cycle long, pin inputs synchronous
// Notes: direction bit 1 means input; overrides never touch stored registers
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`include "gpp_regs.svh"

// Functional notes
// RULE1: five pins, each usable as input or output
// RULE2: direction 0 drives latch, 1 samples pin
// RULE3: enabled peripheral forces pin direction; compare outputs and the serial receive pin keep the stored direction
// RULE4: overrides never stored in direction register
// RULE5: port bits 7:5 enable bus pull-ups
// RULE6: latch/direction bits 7:5 read zero
// RULE7: 64-pin variant: port J pull-up reads zero
// RULE8: compare/PWM outputs replace latch on 0,3,4
// RULE9: enhanced PWM beats latch and PMP
// RULE10: enhanced PWM shutdown may tri-state pins
// RULE11: PMP address drives pins 0..2 regardless
// RULE12: chip selects on 3,4; pin 3 accepts input
// RULE13: serial outputs beat latch on pins 1,2
// RULE14: software sets input for serial receive pin
// RULE15: port write updates latch and pull-ups; read pins
module gpp_port #(
    parameter bit PKG_64PIN = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire gpp_pkg::gpp_pins_t pin_in,
    output gpp_pkg::gpp_pins_t pin_out,
    output gpp_pkg::gpp_pins_t pin_oe,
    output gpp_pkg::gpp_pullup_s membus_pullup_en,
    // compare/PWM outputs: bit0 enh_capcomp_three, bit1 capcomp_four, bit2 capcomp_five
    input wire logic [2:0] capcomp_en,
    input wire logic [2:0] capcomp_out,
    // enhanced PWM: bit0 enh_pwm_three_chan_a, bit1 enh_pwm_three_chan_d, bit2 enh_pwm_one_chan_d
    input wire logic [2:0] enh_pwm_en,
    input wire logic [2:0] enh_pwm_out,
    input wire logic [2:0] enh_pwm_shutdown,
    input wire logic [2:0] enh_pwm_shutdown_tristate,
    // parallel master port: address 8,7,6 on pins 0..2
    input wire logic pmp_addr_en,
    input wire logic [2:0] pmp_addr,
    input wire logic pmp_chip_select_one_en,
    input wire logic pmp_chip_select_one,
    input wire logic pmp_chip_select_one_in_mode,
    input wire logic pmp_chip_select_two_en,
    input wire logic pmp_chip_select_two,
    output logic pmp_chip_select_one_in,
    // serial transceiver two
    input wire logic serial_two_transmit_en,
    input wire logic serial_two_transmit,
    input wire logic serial_two_sync_data_oe,
    input wire logic serial_two_sync_data
);
    // ************************************************************
    // register state
    // ************************************************************
    gpp_pkg::gpp_pins_t lat_q, lat_d;
    gpp_pkg::gpp_pins_t dir_q, dir_d;
    gpp_pkg::gpp_pullup_s pu_q, pu_d;
    logic [7:0] rdata_q, rdata_d;

    function automatic logic [7:0] pad_pins(input gpp_pkg::gpp_pins_t v);
        pad_pins = {3'h0, v}; // RULE6
    endfunction : pad_pins

    always_comb begin
        lat_d = lat_q;
        dir_d = dir_q;
        pu_d = pu_q;
        rdata_d = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                `GPP_OFF_PORT: begin
                    lat_d = reg_wdata[`GPP_PIN_MSB:0]; // RULE15
                    pu_d.d = reg_wdata[`GPP_PU_D_BIT]; // RULE5
                    pu_d.e = reg_wdata[`GPP_PU_E_BIT];
                    pu_d.j = PKG_64PIN ? 1'b0 : reg_wdata[`GPP_PU_J_BIT]; // RULE7
                end
                `GPP_OFF_LAT: lat_d = reg_wdata[`GPP_PIN_MSB:0]; // RULE6
                `GPP_OFF_DIR: dir_d = reg_wdata[`GPP_PIN_MSB:0]; // RULE4
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `GPP_OFF_PORT: rdata_d = {pu_q.d, pu_q.e, pu_q.j, pin_in}; // RULE15
                `GPP_OFF_LAT: rdata_d = pad_pins(lat_q);
                `GPP_OFF_DIR: rdata_d = pad_pins(dir_q); // RULE4
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lat_q <= `GPP_LAT_RST;
            dir_q <= `GPP_DIR_RST;
            pu_q <= `GPP_PU_RST;
            rdata_q <= 8'h00;
        end else begin
            lat_q <= lat_d;
            dir_q <= dir_d;
            pu_q <= pu_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign membus_pullup_en = pu_q;

    // ************************************************************
    // pin multiplexer, highest priority last
    // ************************************************************
    gpp_pkg::gpp_pins_t oe_c, out_c;
    logic [2:0] map_idx [3];
    assign map_idx[0] = 3'h0;
    assign map_idx[1] = 3'h3;
    assign map_idx[2] = 3'h4;

    always_comb begin
        oe_c = ~dir_q; // RULE2 RULE1
        out_c = lat_q;
        // serial receive pin is not forced; software must set its direction
        if (serial_two_transmit_en) begin
            oe_c[1] = 1'b1; // RULE13
            out_c[1] = serial_two_transmit;
        end
        if (serial_two_sync_data_oe) begin
            oe_c[2] = 1'b1; // RULE13 RULE14
            out_c[2] = serial_two_sync_data;
        end
        for (int i = 0; i < 3; i++) begin
            if (capcomp_en[i]) begin
                out_c[map_idx[i]] = capcomp_out[i]; // RULE8
            end
        end
        if (pmp_addr_en) begin
            oe_c[2:0] = 3'h7; // RULE11 RULE3
            out_c[2:0] = pmp_addr;
        end
        if (pmp_chip_select_one_en) begin
            oe_c[3] = ~pmp_chip_select_one_in_mode; // RULE12 RULE3
            out_c[3] = pmp_chip_select_one;
        end
        if (pmp_chip_select_two_en) begin
            oe_c[4] = 1'b1; // RULE12
            out_c[4] = pmp_chip_select_two;
        end
        for (int i = 0; i < 3; i++) begin
            if (enh_pwm_en[i]) begin
                oe_c[map_idx[i]] = ~(enh_pwm_shutdown[i] & enh_pwm_shutdown_tristate[i]); // RULE9 RULE10
                out_c[map_idx[i]] = enh_pwm_out[i]; // RULE9
            end
        end
    end

    assign pin_out = out_c;
    assign pin_oe = oe_c;
    assign pmp_chip_select_one_in = pin_in[3]; // RULE12

    // ************************************************************
    // checks
    // ************************************************************
    a_dir_drives_latch: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        (!dir_q[3] && !capcomp_en[1] && !enh_pwm_en[1] && !pmp_chip_select_one_en) |-> pin_oe[3] && pin_out[3] == lat_q[3])
        else $error("pin 3 not driving latch");
    a_dir_no_override: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        (reg_wr && reg_addr == `GPP_OFF_DIR) |=> dir_q == $past(reg_wdata[4:0]))
        else $error("direction register not software value");
    a_pullup_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        (reg_wr && reg_addr == `GPP_OFF_PORT) |=> membus_pullup_en.d == $past(reg_wdata[7]))
        else $error("pull-up d not written");
    a_lat_high_zero: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        $past(reg_rd) && $past(reg_addr) != `GPP_OFF_PORT |-> reg_rdata[7:5] == 3'h0)
        else $error("unimplemented bits not zero");
    a_j_pullup_64: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
        PKG_64PIN |-> !membus_pullup_en.j)
        else $error("port j pull-up set on 64-pin");
    a_pwm_priority: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
        enh_pwm_en[0] && !enh_pwm_shutdown[0] |-> pin_oe[0] && pin_out[0] == enh_pwm_out[0])
        else $error("pwm lost priority on pin 0");
    a_pwm_tristate: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
        enh_pwm_en[2] && enh_pwm_shutdown[2] && enh_pwm_shutdown_tristate[2] |-> !pin_oe[4])
        else $error("pin 4 driven in shutdown");
    a_pmp_addr: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
        pmp_addr_en && !enh_pwm_en[0] |-> pin_oe[2:0] == 3'h7 && pin_out[2:1] == pmp_addr[2:1])
        else $error("pmp address not driven");
    a_port_read: assert property (@(posedge clk) disable iff (!arst_n) // RULE15
        reg_rd && reg_addr == `GPP_OFF_PORT |=> reg_rdata[4:0] == $past(pin_in))
        else $error("port read not pin levels");

    // ************************************************************
    // checks: pin overrides
    // ************************************************************
    // each override check excludes the sources ranked above it, so a
    // failure points at one priority step rather than at the whole chain
    a_dir_pin0_latch: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        (!dir_q[0] && !capcomp_en[0] && !enh_pwm_en[0] && !pmp_addr_en) |-> pin_oe[0] && pin_out[0] == lat_q[0])
        else $error("pin 0 not driving latch");
    a_dir_pin4_latch: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        (!dir_q[4] && !capcomp_en[2] && !enh_pwm_en[2] && !pmp_chip_select_two_en) |-> pin_oe[4] && pin_out[4] == lat_q[4])
        else $error("pin 4 not driving latch");
    a_dir_pin1_input: assert property (@(posedge clk) disable iff (!arst_n) // RULE2 RULE1
        (dir_q[1] && !serial_two_transmit_en && !pmp_addr_en) |-> !pin_oe[1])
        else $error("pin 1 driven while input");
    a_free_pin_input: assert property (@(posedge clk) disable iff (!arst_n) // RULE2 RULE14
        (dir_q[2] && !serial_two_sync_data_oe && !pmp_addr_en) |-> !pin_oe[2])
        else $error("pin 2 driven while input");
    a_serial_tx_pin: assert property (@(posedge clk) disable iff (!arst_n) // RULE13
        serial_two_transmit_en && !pmp_addr_en |-> pin_oe[1] && pin_out[1] == serial_two_transmit)
        else $error("serial transmit lost pin 1");
    a_serial_data_pin: assert property (@(posedge clk) disable iff (!arst_n) // RULE13
        serial_two_sync_data_oe && !pmp_addr_en |-> pin_oe[2] && pin_out[2] == serial_two_sync_data)
        else $error("serial data lost pin 2");
    a_capcomp_pin0: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
        capcomp_en[0] && !pmp_addr_en && !enh_pwm_en[0] |-> pin_out[0] == capcomp_out[0])
        else $error("compare output lost pin 0");
    a_capcomp_pin3: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
        capcomp_en[1] && !pmp_chip_select_one_en && !enh_pwm_en[1] |-> pin_out[3] == capcomp_out[1])
        else $error("compare output lost pin 3");
    a_capcomp_pin4: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
        capcomp_en[2] && !pmp_chip_select_two_en && !enh_pwm_en[2] |-> pin_out[4] == capcomp_out[2])
        else $error("compare output lost pin 4");
    // compare outputs ride on the stored direction; they never force it
    a_capcomp_keeps_dir: assert property (@(posedge clk) disable iff (!arst_n) // RULE8 RULE3
        capcomp_en[1] && !pmp_chip_select_one_en && !enh_pwm_en[1] |-> pin_oe[3] == !dir_q[3])
        else $error("compare output changed direction");
    a_pwm_pin3: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
        enh_pwm_en[1] && !enh_pwm_shutdown[1] |-> pin_oe[3] && pin_out[3] == enh_pwm_out[1])
        else $error("pwm lost priority on pin 3");
    a_pwm_pin4: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
        enh_pwm_en[2] && !enh_pwm_shutdown[2] |-> pin_oe[4] && pin_out[4] == enh_pwm_out[2])
        else $error("pwm lost priority on pin 4");
    a_pwm_tristate3: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
        enh_pwm_en[1] && enh_pwm_shutdown[1] && enh_pwm_shutdown_tristate[1] |-> !pin_oe[3])
        else $error("pin 3 driven in shutdown");
    a_pwm_sd_drive: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
        enh_pwm_en[0] && enh_pwm_shutdown[0] && !enh_pwm_shutdown_tristate[0] |-> pin_oe[0])
        else $error("pin 0 released without tri-state");
    a_pmp_addr_bit0: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
        pmp_addr_en && !enh_pwm_en[0] |-> pin_out[0] == pmp_addr[0])
        else $error("pmp address bit lost pin 0");
    a_pmp_over_dir: assert property (@(posedge clk) disable iff (!arst_n) // RULE11 RULE3
        pmp_addr_en && dir_q[1] |-> pin_oe[1])
        else $error("pmp address obeyed direction bit");
    a_cs_two_drive: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
        pmp_chip_select_two_en && !enh_pwm_en[2] |-> pin_oe[4] && pin_out[4] == pmp_chip_select_two)
        else $error("chip select two not driven");
    a_cs_one_drive: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
        pmp_chip_select_one_en && !pmp_chip_select_one_in_mode && !enh_pwm_en[1]
        |-> pin_oe[3] && pin_out[3] == pmp_chip_select_one)
        else $error("chip select one not driven");
    a_cs_one_input: assert property (@(posedge clk) disable iff (!arst_n) // RULE12 RULE3
        pmp_chip_select_one_en && pmp_chip_select_one_in_mode && !enh_pwm_en[1] |-> !pin_oe[3])
        else $error("chip select one input driven");
    a_cs_one_in_pin: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
        pmp_chip_select_one_in == pin_in[3])
        else $error("chip select input not pin 3");

    // ************************************************************
    // checks: registers
    // ************************************************************
    // overrides are combinational only, so the stored direction may move
    // solely on a software write to its own offset
    a_dir_hold: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        !(reg_wr && reg_addr == `GPP_OFF_DIR) |=> dir_q == $past(dir_q))
        else $error("direction changed without write");
    a_dir_read_back: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        $past(reg_rd) && $past(reg_addr) == `GPP_OFF_DIR |-> reg_rdata == {3'h0, $past(dir_q)})
        else $error("direction read not stored value");
    a_lat_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        (reg_wr && reg_addr == `GPP_OFF_LAT) |=> lat_q == $past(reg_wdata[`GPP_PIN_MSB:0]))
        else $error("latch write lost");
    a_lat_read_back: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        $past(reg_rd) && $past(reg_addr) == `GPP_OFF_LAT |-> reg_rdata == {3'h0, $past(lat_q)})
        else $error("latch read not stored value");
    a_unused_addr: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        (reg_wr && reg_addr == 2'h3) |=> lat_q == $past(lat_q) && dir_q == $past(dir_q))
        else $error("unused offset changed state");
    a_port_wr_latch: assert property (@(posedge clk) disable iff (!arst_n) // RULE15
        (reg_wr && reg_addr == `GPP_OFF_PORT) |=> lat_q == $past(reg_wdata[`GPP_PIN_MSB:0]))
        else $error("port write missed latch");
    a_pullup_e_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        (reg_wr && reg_addr == `GPP_OFF_PORT) |=> membus_pullup_en.e == $past(reg_wdata[6]))
        else $error("pull-up e not written");
    a_pullup_j_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        (!PKG_64PIN && reg_wr && reg_addr == `GPP_OFF_PORT) |=> membus_pullup_en.j == $past(reg_wdata[5]))
        else $error("pull-up j not written");
    a_pullup_hold: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        !(reg_wr && reg_addr == `GPP_OFF_PORT) |=> membus_pullup_en == $past(membus_pullup_en))
        else $error("pull-ups changed without write");
    a_j_read_64: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
        PKG_64PIN && $past(reg_rd) |-> !reg_rdata[5])
        else $error("port j pull-up read set on 64-pin");
    // read data stand for exactly one cycle so a stray sample sees zero
    a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n) // RULE15
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data without read");
endmodule : gpp_port
